// ===== loopback_pkg.sv
// package: constants and carrier types for the serial loop-back self-test
package loopback_pkg;
   localparam int          CLK_HZ          = 40000000;
   localparam int          TEST_ADDRESS    = 15;             // all four address switches down
   localparam int          ADDR_W          = 4;
   localparam int          DATA_BITS       = 7;              // 7 data, odd parity, 1 stop
   localparam int          BAUD_DEFAULT    = 1200;
   localparam int          CHAR_COUNT      = 4;              // characters sent per test
   localparam int          PRINT_MIN_MS    = 25;             // least print-request activation
   localparam int          PRINT_MIN_CYC   = (CLK_HZ / 1000) * PRINT_MIN_MS;
   localparam int          TIMEOUT_CHARS   = 3;              // char times allowed per echo
   localparam logic [15:0] PASS_MARKER     = 16'h1111;       // bcd digits of 0.1111
   localparam int          SCALE_W         = 16;
   localparam logic [6:0]  PATTERN_SEED    = 7'h55;

   // one received character, with its error flag
   typedef struct packed {
      logic       valid;
      logic [6:0] data;
      logic       bad;     // start, parity or stop failure
   } char_t;
endpackage

// ===== loopback_uart.sv
// 7-bit odd-parity serial transmitter and receiver for the loop-back test
`timescale 1ns/1ps
module loopback_uart #(
   parameter int BIT_CYC = 33333               // clock cycles per bit
) (
   input  wire logic                 clk_i,      // system clock
   input  wire logic                 reset_n_i,  // sync reset, active low
   input  wire logic                 send_i,     // pulse: start a character
   input  wire logic [6:0]           send_data_i,// character to send
   input  wire logic                 rx_i,       // serial in, 1 = mark
   output logic                      tx_o,       // serial out, 1 = mark
   output logic                      tx_busy_o,  // transmitter busy
   output loopback_pkg::char_t       rx_char_o   // one-cycle received character
);
   typedef struct packed {
      logic [9:0]  tx_sh;
      logic [3:0]  tx_cnt;
      logic [31:0] tx_tmr;
      logic        tx;
      logic        busy;
      logic [1:0]  rx_sync;
      logic        rx_on;
      logic [3:0]  rx_cnt;
      logic [31:0] rx_tmr;
      logic [9:0]  rx_sh;
      loopback_pkg::char_t out;
   } uart_t;

   uart_t s_reg;
   uart_t s_next;

   // frame is start, 7 data lsb first, odd parity, stop
   always_comb begin
      s_next     = s_reg;
      s_next.out = '0;
      s_next.rx_sync = {s_reg.rx_sync[0], rx_i};
      if (!s_reg.busy) begin
         if (send_i) begin
            // start bit goes out at once, so it lasts exactly one bit time
            s_next.tx     = 1'b0;
            s_next.tx_sh  = {2'b11, ~(^send_data_i), send_data_i};
            s_next.busy   = 1'b1;
            s_next.tx_cnt = 4'h0;
            s_next.tx_tmr = 32'h0;
         end
      end else if (s_reg.tx_tmr == 32'(BIT_CYC - 1)) begin
         s_next.tx_tmr = 32'h0;
         s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
         if (s_reg.tx_cnt == 4'h9) begin
            // end of the stop bit: line back to mark
            s_next.busy = 1'b0;
            s_next.tx   = 1'b1;
         end else begin
            s_next.tx    = s_reg.tx_sh[0];
            s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
         end
      end else begin
         s_next.tx_tmr = s_reg.tx_tmr + 32'h1;
      end
      // receiver samples mid-bit; reads only the second sync stage
      if (!s_reg.rx_on) begin
         if (!s_reg.rx_sync[1]) begin
            s_next.rx_on  = 1'b1;
            s_next.rx_cnt = 4'h0;
            s_next.rx_tmr = 32'(BIT_CYC / 2);
         end
      end else if (s_reg.rx_tmr == 32'(BIT_CYC - 1)) begin
         s_next.rx_tmr = 32'h0;
         s_next.rx_sh  = {s_reg.rx_sync[1], s_reg.rx_sh[9:1]};
         s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
         if (s_reg.rx_cnt == 4'h9) begin
            s_next.rx_on     = 1'b0;
            s_next.out.valid = 1'b1;
            s_next.out.data  = s_reg.rx_sh[8:2];
            // bad if start not low, parity even, or stop not high
            s_next.out.bad   = s_reg.rx_sh[1] | ~(^s_reg.rx_sh[9:2])
                               | ~s_reg.rx_sync[1];
         end
      end else begin
         s_next.rx_tmr = s_reg.rx_tmr + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s_reg         <= '0;
         s_reg.tx      <= 1'b1;
         s_reg.rx_sync <= 2'b11;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tx_o      = s_reg.tx;
   assign tx_busy_o = s_reg.busy;
   assign rx_char_o = s_reg.out;

   // a stop slot of zero must be flagged bad
   a_stop_bad: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_reg.rx_on && s_reg.rx_cnt == 4'h9 && s_reg.rx_tmr == 32'(BIT_CYC - 1)
       && !s_reg.rx_sync[1]) |=> (rx_char_o.valid && rx_char_o.bad))
      else $error("stop bit failure not flagged");
   // transmit line idles at mark when not busy
   a_tx_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!tx_busy_o && !$past(tx_busy_o)) |-> tx_o)
      else $error("tx not at mark while idle");
endmodule

// ===== serial_loopback_self_test.sv
// top: power-up serial loop-back self-test with scale-factor pass marker
// Summary of operation
// - address switches at 15 on power-up start the loop-back test.
// - all characters echoed correctly overwrite working scale factor with 0.1111.
// - keypad key 3 shows the current scale factor.
// - after a pass, releasing print-request from common restores stored scale.
// - failed test leaves scale factor alone; retried only on next power-up.
// - characters are one start, seven data, odd parity, one stop.
// - print-request honoured only while serial input loop is at mark.
`timescale 1ns/1ps
module serial_loopback_self_test #(
   parameter int BAUD          = loopback_pkg::BAUD_DEFAULT, // bit rate
   parameter int PRINT_MIN_CYC = loopback_pkg::PRINT_MIN_CYC // 25 ms in cycles
) (
   input  wire logic                              clk_i,          // 40 MHz clock
   input  wire logic                              reset_n_i,      // power-up reset, active low
   input  wire logic [loopback_pkg::ADDR_W-1:0]   unit_address_i, // address switches
   input  wire logic [loopback_pkg::SCALE_W-1:0]  stored_scale_i, // stored scale factor
   input  wire logic                              key3_i,         // keypad key 3 held
   input  wire logic                              print_req_n_i,  // low = tied to common
   input  wire logic                              serial_in_i,    // loop in, 1 = mark
   output logic                                   serial_out_o,   // loop out, 1 = mark
   output logic [loopback_pkg::SCALE_W-1:0]       scale_o,        // working scale factor
   output logic [loopback_pkg::SCALE_W-1:0]       display_o,      // displayed value
   output logic                                   display_scale_o,// display shows scale
   output logic                                   test_pass_o,    // test passed
   output logic                                   test_done_o,    // test finished
   output logic                                   print_o         // print-request accepted
);
   localparam int BIT_CYC     = loopback_pkg::CLK_HZ / BAUD;
   localparam int TIMEOUT_CYC = BIT_CYC * 11 * loopback_pkg::TIMEOUT_CHARS;

   typedef enum logic [5:0] {
      ST_LATCH = 6'h01,
      ST_SEND  = 6'h02,
      ST_WAIT  = 6'h04,
      ST_PASS  = 6'h08,
      ST_FAIL  = 6'h10,
      ST_IDLE  = 6'h20
   } state_t;

   typedef struct packed {
      state_t      st;
      logic [1:0]  idx;
      logic [6:0]  expect_c;
      logic [31:0] tmr;
      logic [31:0] pr_cnt;
      logic        pr_seen;
      logic        marker_on;
      logic [15:0] scale;
      logic [15:0] disp;
      logic        disp_sc;
      logic        pass;
      logic        done;
      logic        send;
      logic        print;
      logic        line;         // registered copy of the tx line
   } top_t;

   top_t s_reg;
   top_t s_next;

   logic                tx_line;
   logic                tx_busy;
   loopback_pkg::char_t rx_char;

   loopback_uart #(
      .BIT_CYC (BIT_CYC)
   ) loopback_uart_inst (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .send_i      (s_reg.send),
      .send_data_i (s_reg.expect_c),
      .rx_i        (serial_in_i),
      .tx_o        (tx_line),
      .tx_busy_o   (tx_busy),
      .rx_char_o   (rx_char)
   );

   // test sequencer, scale-factor control and print-request qualifier
   always_comb begin
      s_next       = s_reg;
      s_next.send  = 1'b0;
      s_next.print = 1'b0;
      s_next.line  = tx_line;   // extra flop keeps the pin registered
      case (s_reg.st)
         ST_LATCH: begin
            // address caught once, after reset release, never under reset
            s_next.scale = stored_scale_i;
            if (unit_address_i == 4'(loopback_pkg::TEST_ADDRESS)) begin
               s_next.st       = ST_SEND;
               s_next.expect_c = loopback_pkg::PATTERN_SEED;
               s_next.idx      = 2'h0;
            end else begin
               s_next.st   = ST_IDLE;
               s_next.done = 1'b1;
            end
         end
         ST_SEND: begin
            if (!tx_busy) begin
               s_next.send = 1'b1;
               s_next.tmr  = 32'h0;
               s_next.st   = ST_WAIT;
            end
         end
         ST_WAIT: begin
            s_next.tmr = s_reg.tmr + 32'h1;
            if (rx_char.valid) begin
               if (rx_char.bad || rx_char.data != s_reg.expect_c) begin
                  s_next.st = ST_FAIL;
               end else if (s_reg.idx == 2'(loopback_pkg::CHAR_COUNT - 1)) begin
                  s_next.st = ST_PASS;
               end else begin
                  s_next.idx      = s_reg.idx + 2'h1;
                  s_next.expect_c = ~s_reg.expect_c + 7'h03; // varied pattern
                  s_next.st       = ST_SEND;
               end
            end else if (s_reg.tmr == 32'(TIMEOUT_CYC)) begin
               s_next.st = ST_FAIL;
            end
         end
         ST_PASS: begin
            s_next.scale     = loopback_pkg::PASS_MARKER;
            s_next.marker_on = 1'b1;
            s_next.pass      = 1'b1;
            s_next.done      = 1'b1;
            s_next.st        = ST_IDLE;
         end
         ST_FAIL: begin
            // scale stays as stored; no retry until the next reset
            s_next.done = 1'b1;
            s_next.st   = ST_IDLE;
         end
         ST_IDLE: begin
            // print-request counted only with loop current flowing
            if (!print_req_n_i && serial_in_i) begin
               if (s_reg.pr_cnt != 32'(PRINT_MIN_CYC)) begin
                  s_next.pr_cnt = s_reg.pr_cnt + 32'h1;
               end else begin
                  if (!s_reg.pr_seen) begin
                     s_next.print = 1'b1;
                  end
                  s_next.pr_seen = 1'b1;
               end
            end else begin
               s_next.pr_cnt = 32'h0;
            end
            if (print_req_n_i) begin
               s_next.pr_seen = 1'b0;
               if (s_reg.marker_on) begin
                  s_next.scale     = stored_scale_i;
                  s_next.marker_on = 1'b0;
               end
            end
         end
         default: begin
            s_next.st = ST_IDLE;
         end
      endcase
      // key 3 routes the scale factor to the display
      s_next.disp_sc = key3_i;
      s_next.disp    = key3_i ? s_next.scale : 16'h0000;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s_reg      <= '0;
         s_reg.st   <= ST_LATCH;
         s_reg.line <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign serial_out_o    = s_reg.line;
   assign scale_o         = s_reg.scale;
   assign display_o       = s_reg.disp;
   assign display_scale_o = s_reg.disp_sc;
   assign test_pass_o     = s_reg.pass;
   assign test_done_o     = s_reg.done;
   assign print_o         = s_reg.print;

   a_addr_starts: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_reg.st == ST_LATCH && unit_address_i == 4'hF) |=> s_reg.st == ST_SEND)
      else $error("test not started at address 15");
   a_no_test_other: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_reg.st == ST_LATCH && unit_address_i != 4'hF) |=> ##1 !test_pass_o)
      else $error("test ran at wrong address");
   a_pass_marker: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_reg.st == ST_PASS) |=> (scale_o == 16'h1111 && test_pass_o))
      else $error("pass marker not loaded");
   a_key3_show: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (key3_i && s_reg.st == ST_IDLE && !print_req_n_i) |=> display_o == $past(scale_o))
      else $error("key 3 did not show scale");
   a_restore: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_reg.st == ST_IDLE && s_reg.marker_on && print_req_n_i)
      |=> scale_o == $past(stored_scale_i))
      else $error("scale not restored on release");
   a_fail_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_reg.st == ST_FAIL) |=> (!test_pass_o && test_done_o && scale_o == $past(scale_o)))
      else $error("failed test changed scale");
   a_print_mark: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      print_o |-> $past(serial_in_i) && $past(!print_req_n_i))
      else $error("print accepted without mark");
   a_bad_fails: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (s_reg.st == ST_WAIT && rx_char.valid && rx_char.bad) |=> s_reg.st == ST_FAIL)
      else $error("bad echo did not fail test");
   a_print_len: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      print_o |-> $past(s_reg.pr_cnt) == 32'(PRINT_MIN_CYC))
      else $error("print accepted too early");
   // display selection follows key 3 one cycle later
   a_key3_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      key3_i |=> display_scale_o)
      else $error("key 3 did not select scale");
   a_key3_blank: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !key3_i |=> display_o == 16'h0000)
      else $error("display not blank without key 3");
endmodule

// ===== loop_partner.sv
// partner model: the device's own serial output wired back into its serial input
`timescale 1ns/1ps
module loop_partner (
   input  wire logic       clk_i,     // system clock
   input  wire logic       tx_i,      // device serial out, 1 = mark
   input  wire logic       open_i,    // loop broken, no current
   input  wire logic       corrupt_i, // loop wired with wrong polarity
   input  wire logic [3:0] delay_i,   // echo delay in clock cycles
   output logic            rx_o       // device serial in, 1 = mark
);
   logic [15:0] dly_reg = 16'hFFFF;   // starts at mark, as an idle loop does
   logic        echo;

   // a slow loop is modelled as a fixed delay in the echo
   always_ff @(posedge clk_i) begin
      dly_reg <= {dly_reg[14:0], tx_i};
   end

   // an open loop carries no current, so the input reads space, never the last value
   always_comb begin
      echo = (delay_i == 4'h0) ? tx_i : dly_reg[delay_i - 4'h1];
      rx_o = open_i ? 1'b0 : (corrupt_i ? ~echo : echo);
   end
endmodule

// ===== testbench.sv
// self-checking testbench for the serial loop-back self-test
`timescale 1ns/1ps
module testbench;
   localparam int BIT_CYC = 10;      // 40 MHz / 4 Mbit/s
   localparam int PMIN    = 20;      // shortened print-request count
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [3:0]  unit_address_i = 4'h0;
   logic [15:0] stored_scale_i = 16'h1234;
   logic        key3_i = 1'b0;
   logic        print_req_n_i = 1'b1;
   logic        serial_in_i;
   logic        serial_out_o, display_scale_o, test_pass_o, test_done_o, print_o;
   logic [15:0] scale_o, display_o;
   logic        open_i = 1'b0;
   logic        corrupt_i = 1'b0;
   logic [3:0]  delay_i = 4'h0;
   int          fails = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   always #12.5 clk_i = ~clk_i;

   serial_loopback_self_test #(.BAUD(4000000), .PRINT_MIN_CYC(PMIN))
   serial_loopback_self_test_inst (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .unit_address_i(unit_address_i),
      .stored_scale_i(stored_scale_i), .key3_i(key3_i), .print_req_n_i(print_req_n_i),
      .serial_in_i(serial_in_i), .serial_out_o(serial_out_o), .scale_o(scale_o),
      .display_o(display_o), .display_scale_o(display_scale_o),
      .test_pass_o(test_pass_o), .test_done_o(test_done_o), .print_o(print_o));

   loop_partner loop_partner_inst (
      .clk_i(clk_i), .tx_i(serial_out_o), .open_i(open_i), .corrupt_i(corrupt_i),
      .delay_i(delay_i), .rx_o(serial_in_i));

   // inputs always move 2 ns after the rising edge, clear of sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // power-up: address switches are read only in the first edge after release
   task automatic power_up(input logic [3:0] addr, input logic [15:0] stored);
      reset_n_i = 1'b0;
      unit_address_i = addr;
      stored_scale_i = stored;
      step(16);
      reset_n_i = 1'b1;
   endtask

   task automatic wait_done(input int max);
      int i;
      i = 0;
      while (test_done_o !== 1'b1 && i < max) begin
         step(1);
         i++;
      end
      check({15'h0, test_done_o}, 16'h0001);
   endtask

   // counts cycles in which print_o is high, or serial_out_o is low
   task automatic count_high(input int n, input bit watch_print, output int hits);
      hits = 0;
      repeat (n) begin
         step(1);
         if (watch_print ? (print_o === 1'b1) : (serial_out_o !== 1'b1)) hits++;
      end
   endtask

   task automatic pass_run();
      logic [9:0] line;
      int         i;
      delay_i = 4'hC;                                  // slow echo still inside timeout
      print_req_n_i = 1'b0;                            // held at common keeps the marker
      power_up(4'hF, 16'h1234);
      i = 0;
      while (serial_out_o !== 1'b0 && i < 300) begin
         step(1);
         i++;
      end
      step(BIT_CYC / 2);
      for (int b = 0; b < 10; b++) begin
         line[b] = serial_out_o;
         step(BIT_CYC);
      end
      check({6'h0, line}, {6'h0, 1'b1, ~^7'h55, 7'h55, 1'b0});
      wait_done(3000);
      check({15'h0, test_pass_o}, 16'h0001);
      check(scale_o, 16'h1111);
      key3_i = 1'b1;
      step(2);
      check({15'h0, display_scale_o}, 16'h0001);
      check(display_o, 16'h1111);
      key3_i = 1'b0;
      step(2);
      check(display_o, 16'h0000);
      check({15'h0, display_scale_o}, 16'h0000);
      print_req_n_i = 1'b1;
      step(2);
      check(scale_o, 16'h1234);
   endtask

   task automatic print_run();
      int n;
      int hits;
      print_req_n_i = 1'b0;
      n = 0;
      while (print_o !== 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      check({15'h0, (n >= PMIN && n <= PMIN + 4)}, 16'h0001);
      count_high(40, 1'b1, hits);                      // one pulse per activation
      check(hits[15:0], 16'h0000);
      print_req_n_i = 1'b1;
      step(2);
      open_i = 1'b1;                                   // loop at space
      print_req_n_i = 1'b0;
      count_high(3 * PMIN, 1'b1, hits);
      check(hits[15:0], 16'h0000);
      print_req_n_i = 1'b1;
      open_i = 1'b0;
      step(2);
   endtask

   task automatic fail_run();
      int hits;
      delay_i = 4'h0;
      corrupt_i = 1'b1;                                // echo arrives inverted
      print_req_n_i = 1'b0;
      power_up(4'hF, 16'h0987);
      wait_done(3000);
      check({15'h0, test_pass_o}, 16'h0000);
      check(scale_o, 16'h0987);
      corrupt_i = 1'b0;
      step(11 * BIT_CYC);                              // let a frame in flight drain
      count_high(300, 1'b0, hits);                     // no retry without power-up
      check(hits[15:0], 16'h0000);
      check(scale_o, 16'h0987);
      print_req_n_i = 1'b1;
   endtask

   task automatic skip_run();
      int hits;
      power_up(4'h7, 16'h4321);
      count_high(300, 1'b0, hits);                     // nothing sent off address 15
      check(hits[15:0], 16'h0000);
      check({14'h0, test_done_o, test_pass_o}, 16'h0002);
      check(scale_o, 16'h4321);
   endtask

   // the ceiling is several times the expected run, so only a hang reaches it
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end

   initial begin
      pass_run();
      print_run();
      fail_run();
      skip_run();
      tally_and_finish();
   end
endmodule
